// ### rtl/hte_pkg.sv
// constants, types and cause helper shared by the trap-entry block
package hte_pkg;
  localparam int XLEN = 64;
  localparam int CODE_W = 6;
  localparam int IRQ_W = 16;
  typedef enum logic [1:0] {HTE_TO_M, HTE_TO_HS, HTE_TO_VS} hte_target_t;
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;
  localparam logic [1:0] RST_PRIV = PRIV_M;
  localparam logic [1:0] RST_MPP = PRIV_U;
  localparam logic RST_IE = 1'h0;
  // interrupt codes
  localparam logic [5:0] IRQ_SSI = 6'h01;
  localparam logic [5:0] IRQ_VSSI = 6'h02;
  localparam logic [5:0] IRQ_MSI = 6'h03;
  localparam logic [5:0] IRQ_STI = 6'h05;
  localparam logic [5:0] IRQ_VSTI = 6'h06;
  localparam logic [5:0] IRQ_MTI = 6'h07;
  localparam logic [5:0] IRQ_SEI = 6'h09;
  localparam logic [5:0] IRQ_VSEI = 6'h0a;
  localparam logic [5:0] IRQ_MEI = 6'h0b;
  localparam logic [5:0] IRQ_SGEI = 6'h0c;
  localparam int IRQ_NUM = 10;
  // index 0 is the highest priority
  localparam logic [5:0] IRQ_ORDER [IRQ_NUM] = '{IRQ_MEI, IRQ_MSI, IRQ_MTI, IRQ_SEI, IRQ_SSI,
    IRQ_STI, IRQ_SGEI, IRQ_VSEI, IRQ_VSSI, IRQ_VSTI};
  // codes 0, 4, 8, 13..15
  localparam logic [15:0] IRQ_RSVD_MASK = 16'he111;
  // exception codes
  localparam logic [5:0] EXC_ILLEGAL = 6'h02;
  localparam logic [5:0] ENVIRONMENT_CALL_INSTR_U = 6'h08;
  localparam logic [5:0] ENVIRONMENT_CALL_INSTR_HS = 6'h09;
  localparam logic [5:0] ENVIRONMENT_CALL_INSTR_VS = 6'h0a;
  localparam logic [5:0] ENVIRONMENT_CALL_INSTR_M = 6'h0b;
  localparam logic [5:0] GPF_INSTR = 6'h14;
  localparam logic [5:0] GPF_LOAD = 6'h15;
  localparam logic [5:0] GPF_STORE = 6'h17;
  // codes 14, 16..19, 22, 32..47
  localparam logic [63:0] EXC_RSVD_MASK = 64'h0000_ffff_004f_4000;
  localparam int GPA_SHIFT = 2;
  // wfi time limit in guest and user modes
  localparam int CLK_PERIOD_NS = 50;
  localparam int WFI_LIMIT_NS = 10000;
  localparam int WFI_LIMIT_CYC = WFI_LIMIT_NS / CLK_PERIOD_NS;
  localparam int WFI_CNT_W = 8;
  localparam logic [WFI_CNT_W-1:0] WFI_LAST = WFI_CNT_W'(WFI_LIMIT_CYC - 1);

  function automatic logic [XLEN-1:0] hte_cause(input logic is_int, input logic [CODE_W-1:0] code);
    return {is_int, {(XLEN-CODE_W-1){1'b0}}, code};
  endfunction
endpackage

// ### rtl/hte_trap_if.sv
// trap request passed between cause encoder, delegation and trap entry
`timescale 1ns/1ps
`default_nettype none
interface hte_trap_if;
  logic valid;
  logic is_int;
  logic [hte_pkg::CODE_W-1:0] code;
  logic gpf;
  hte_pkg::hte_target_t target;
  modport enc (output valid, is_int, code, gpf);
  modport dlg (input valid, is_int, code, gpf, output target);
  modport core (input valid, is_int, code, gpf, target);
endinterface
`default_nettype wire

// ### rtl/hte_cause_enc.sv
// picks the trap to take and encodes its cause
`timescale 1ns/1ps
`default_nettype none
module hte_cause_enc (
  hte_trap_if.enc trap,
  input wire logic [1:0] priv,
  input wire logic virt,
  input wire logic [15:0] int_pending,
  input wire logic exc_valid,
  input wire logic [5:0] exc_code,
  input wire logic environment_call_instr_valid,
  input wire logic wfi_timeout
);
  logic [15:0] pend;
  logic irq_hit;
  logic [5:0] irq_code;
  logic [5:0] environment_call_instr_code;
  logic exc_ok;

  // lowest priority first so the highest pending one wins
  always_comb
  begin
    pend = int_pending & ~hte_pkg::IRQ_RSVD_MASK;
    irq_hit = 1'b0;
    irq_code = 6'h00;
    for (int i = hte_pkg::IRQ_NUM - 1; i >= 0; i--)
    begin
      if (pend[hte_pkg::IRQ_ORDER[i][3:0]])
      begin
        irq_hit = 1'b1;
        irq_code = hte_pkg::IRQ_ORDER[i];
      end
    end
  end

  always_comb
  begin
    if (priv == hte_pkg::PRIV_M)
      environment_call_instr_code = hte_pkg::ENVIRONMENT_CALL_INSTR_M;
    else if (priv == hte_pkg::PRIV_U)
      environment_call_instr_code = hte_pkg::ENVIRONMENT_CALL_INSTR_U;
    else if (virt)
      environment_call_instr_code = hte_pkg::ENVIRONMENT_CALL_INSTR_VS;
    else
      environment_call_instr_code = hte_pkg::ENVIRONMENT_CALL_INSTR_HS;
  end

  // reserved codes are never generated; such a report is dropped
  assign exc_ok = exc_valid && !hte_pkg::EXC_RSVD_MASK[exc_code];

  always_comb
  begin
    trap.valid = irq_hit || wfi_timeout || environment_call_instr_valid || exc_ok;
    trap.is_int = irq_hit;
    trap.gpf = 1'b0;
    if (irq_hit)
      trap.code = irq_code;
    else if (wfi_timeout)
      trap.code = hte_pkg::EXC_ILLEGAL;
    else if (environment_call_instr_valid)
      trap.code = environment_call_instr_code;
    else if (exc_ok)
    begin
      trap.code = exc_code;
      trap.gpf = exc_code == hte_pkg::GPF_INSTR || exc_code == hte_pkg::GPF_LOAD
        || exc_code == hte_pkg::GPF_STORE;
    end
    else
      trap.code = 6'h00;
  end
endmodule
`default_nettype wire

// ### rtl/hte_deleg.sv
// chooses the privilege that takes the trap
`timescale 1ns/1ps
`default_nettype none
module hte_deleg (
  hte_trap_if.dlg trap,
  input wire logic [1:0] priv,
  input wire logic virt,
  input wire logic [63:0] mach_exc_deleg,
  input wire logic [63:0] mach_int_deleg,
  input wire logic [63:0] hyp_exc_deleg,
  input wire logic [63:0] hyp_int_deleg
);
  logic m_del;
  logic h_del;

  always_comb
  begin
    m_del = trap.is_int ? mach_int_deleg[trap.code] : mach_exc_deleg[trap.code];
    // guest-page faults stop at the hypervisor level
    h_del = trap.is_int ? hyp_int_deleg[trap.code] : hyp_exc_deleg[trap.code] && !trap.gpf;
    if (priv == hte_pkg::PRIV_M || !m_del)
      trap.target = hte_pkg::HTE_TO_M;
    else if (!virt || !h_del)
      trap.target = hte_pkg::HTE_TO_HS;
    else
      trap.target = hte_pkg::HTE_TO_VS;
  end
endmodule
`default_nettype wire

// ### rtl/hte_trap_entry.sv
// trap entry state of a hart with hypervisor support
// What this block does
// - guest-mode wait for interrupt traps illegal unless woken within a bounded time
// - guest supervisor and guest user wait behaves as in user mode
// - virtual supervisor software interrupt reports interrupt code 2
// - virtual supervisor timer interrupt reports interrupt code 6
// - virtual supervisor external interrupt reports interrupt code 10
// - supervisor guest external interrupt reports interrupt code 12
// - interrupt codes 0, 4, 8, 13..15 reserved; 16 and up platform
// - guest-page faults report exception codes 20, 21, 23; 22 reserved
// - environment call from guest supervisor is 10, from hypervisor level 9
// - environment call from user or guest user is 8, machine is 11
// - custom and reserved exception codes; reserved ones are never raised
// - hypervisor or user traps go to machine unless machine-delegated
// - guest traps go machine, then hypervisor, then guest by delegation
// - machine entry clears guest context and records prior guest flag and privilege
// - machine entry updates address flag, enables and machine trap registers
// - machine return ignores prior guest flag when prior privilege is 3
// - hypervisor entry clears guest context and records prior flag and privilege
// - prior guest privilege copied only when guest context was set
// - hypervisor entry updates address flag, enables and supervisor trap registers
// - guest entry records prior privilege, keeps hypervisor status and guest context
// - guest entry updates guest enables, pc, cause and value
// - guest-page fault second value is zero or guest address shifted by two
// - guest-page faults delegate only down to the hypervisor level
// - interrupts write zero to the trap instruction register
`timescale 1ns/1ps
`default_nettype none
module hte_trap_entry (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] int_pending,
  input wire logic exc_valid,
  input wire logic [5:0] exc_code,
  input wire logic environment_call_instr_valid,
  input wire logic wfi_valid,
  input wire logic wfi_wake,
  input wire logic mret_valid,
  input wire logic [63:0] trap_pc,
  input wire logic [63:0] trap_tval,
  input wire logic [63:0] trap_gpa,
  input wire logic [63:0] trap_tinst,
  input wire logic trap_gva,
  input wire logic [63:0] mach_exc_deleg,
  input wire logic [63:0] mach_int_deleg,
  input wire logic [63:0] hyp_exc_deleg,
  input wire logic [63:0] hyp_int_deleg,
  input wire logic ie_wr_en,
  input wire logic [2:0] ie_wr_val,
  output var logic [1:0] privilege,
  output var logic guest_context_flag,
  output var logic wfi_waiting,
  output var logic trap_taken,
  output var hte_pkg::hte_target_t trap_target,
  output var logic [63:0] trap_cause,
  output var logic machine_prior_guest_flag,
  output var logic [1:0] machine_prior_privilege,
  output var logic guest_address_flag,
  output var logic machine_prior_int_enable,
  output var logic machine_int_enable,
  output var logic [63:0] machine_exception_pc,
  output var logic [63:0] machine_trap_cause,
  output var logic [63:0] machine_trap_value,
  output var logic [63:0] machine_trap_value_two,
  output var logic [63:0] machine_trap_instr,
  output var logic sup_prior_guest_flag,
  output var logic sup_prior_privilege,
  output var logic sup_prior_guest_privilege,
  output var logic hyp_guest_address_flag,
  output var logic sup_prior_int_enable,
  output var logic sup_int_enable,
  output var logic [63:0] sup_exception_pc,
  output var logic [63:0] sup_trap_cause,
  output var logic [63:0] sup_trap_value,
  output var logic [63:0] hyp_trap_value,
  output var logic [63:0] hyp_trap_instr,
  output var logic guest_prior_privilege,
  output var logic guest_prior_int_enable,
  output var logic guest_int_enable,
  output var logic [63:0] guest_sup_exception_pc,
  output var logic [63:0] guest_sup_trap_cause,
  output var logic [63:0] guest_sup_trap_value
);
  hte_trap_if trap_bus ();
  logic [hte_pkg::WFI_CNT_W-1:0] wfi_cnt_reg;
  logic wfi_timed;
  logic wfi_timeout;
  logic take;
  logic to_m;
  logic to_hs;
  logic to_vs;
  logic ret;
  logic [63:0] cause;
  logic [63:0] gpa_val;
  logic [63:0] tinst_val;

  hte_cause_enc u_enc (
    .trap(trap_bus.enc),
    .priv(privilege),
    .virt(guest_context_flag),
    .int_pending(int_pending),
    .exc_valid(exc_valid),
    .exc_code(exc_code),
    .environment_call_instr_valid(environment_call_instr_valid),
    .wfi_timeout(wfi_timeout)
  );

  hte_deleg u_deleg (
    .trap(trap_bus.dlg),
    .priv(privilege),
    .virt(guest_context_flag),
    .mach_exc_deleg(mach_exc_deleg),
    .mach_int_deleg(mach_int_deleg),
    .hyp_exc_deleg(hyp_exc_deleg),
    .hyp_int_deleg(hyp_int_deleg)
  );

  assign take = trap_bus.valid;
  assign to_m = take && trap_bus.target == hte_pkg::HTE_TO_M;
  assign to_hs = take && trap_bus.target == hte_pkg::HTE_TO_HS;
  assign to_vs = take && trap_bus.target == hte_pkg::HTE_TO_VS;
  // a trap in the same cycle wins over a return
  assign ret = mret_valid && !take;
  assign cause = hte_pkg::hte_cause(trap_bus.is_int, trap_bus.code);
  assign gpa_val = trap_bus.gpf ? trap_gpa >> hte_pkg::GPA_SHIFT : 64'h0000_0000_0000_0000;
  assign tinst_val = trap_bus.is_int ? 64'h0000_0000_0000_0000 : trap_tinst;

  // hypervisor level waits forever; guest and user levels are bounded
  assign wfi_timed = guest_context_flag || privilege == hte_pkg::PRIV_U;
  assign wfi_timeout = wfi_waiting && wfi_timed && !wfi_wake
    && wfi_cnt_reg == hte_pkg::WFI_LAST;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wfi_waiting <= 1'b0;
      wfi_cnt_reg <= '0;
    end
    else if (take || wfi_wake)
    begin
      wfi_waiting <= 1'b0;
      wfi_cnt_reg <= '0;
    end
    else if (wfi_valid)
    begin
      wfi_waiting <= 1'b1;
      wfi_cnt_reg <= '0;
    end
    else if (wfi_waiting && wfi_timed)
      wfi_cnt_reg <= wfi_cnt_reg + 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      privilege <= hte_pkg::RST_PRIV;
      guest_context_flag <= 1'b0;
    end
    else if (to_m)
    begin
      privilege <= hte_pkg::PRIV_M;
      guest_context_flag <= 1'b0;
    end
    else if (to_hs)
    begin
      privilege <= hte_pkg::PRIV_S;
      guest_context_flag <= 1'b0;
    end
    else if (to_vs)
      privilege <= hte_pkg::PRIV_S;
    else if (ret)
    begin
      privilege <= machine_prior_privilege;
      guest_context_flag <= machine_prior_privilege != hte_pkg::PRIV_M
        && machine_prior_guest_flag;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      trap_taken <= 1'b0;
      trap_target <= hte_pkg::HTE_TO_M;
      trap_cause <= '0;
    end
    else
    begin
      trap_taken <= take;
      if (take)
      begin
        trap_target <= trap_bus.target;
        trap_cause <= cause;
      end
    end
  end

  // machine status fields
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      machine_prior_guest_flag <= 1'b0;
      machine_prior_privilege <= hte_pkg::RST_MPP;
      guest_address_flag <= 1'b0;
      machine_prior_int_enable <= hte_pkg::RST_IE;
      machine_int_enable <= hte_pkg::RST_IE;
    end
    else if (to_m)
    begin
      machine_prior_guest_flag <= guest_context_flag;
      machine_prior_privilege <= privilege;
      guest_address_flag <= trap_gva;
      machine_prior_int_enable <= machine_int_enable;
      machine_int_enable <= 1'b0;
    end
    else if (ret)
    begin
      machine_prior_guest_flag <= 1'b0;
      machine_prior_privilege <= hte_pkg::PRIV_U;
      machine_prior_int_enable <= 1'b1;
      machine_int_enable <= machine_prior_int_enable;
    end
    else if (ie_wr_en)
      machine_int_enable <= ie_wr_val[0];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      machine_exception_pc <= '0;
      machine_trap_cause <= '0;
      machine_trap_value <= '0;
      machine_trap_value_two <= '0;
      machine_trap_instr <= '0;
    end
    else if (to_m)
    begin
      machine_exception_pc <= trap_pc;
      machine_trap_cause <= cause;
      machine_trap_value <= trap_tval;
      machine_trap_value_two <= gpa_val;
      machine_trap_instr <= tinst_val;
    end
  end

  // hypervisor-level status fields
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sup_prior_guest_flag <= 1'b0;
      sup_prior_privilege <= 1'b0;
      sup_prior_guest_privilege <= 1'b0;
      hyp_guest_address_flag <= 1'b0;
      sup_prior_int_enable <= hte_pkg::RST_IE;
      sup_int_enable <= hte_pkg::RST_IE;
    end
    else if (to_hs)
    begin
      sup_prior_guest_flag <= guest_context_flag;
      sup_prior_privilege <= privilege[0];
      if (guest_context_flag)
        sup_prior_guest_privilege <= privilege[0];
      hyp_guest_address_flag <= trap_gva;
      sup_prior_int_enable <= sup_int_enable;
      sup_int_enable <= 1'b0;
    end
    else if (ie_wr_en)
      sup_int_enable <= ie_wr_val[1];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sup_exception_pc <= '0;
      sup_trap_cause <= '0;
      sup_trap_value <= '0;
      hyp_trap_value <= '0;
      hyp_trap_instr <= '0;
    end
    else if (to_hs)
    begin
      sup_exception_pc <= trap_pc;
      sup_trap_cause <= cause;
      sup_trap_value <= trap_tval;
      hyp_trap_value <= gpa_val;
      hyp_trap_instr <= tinst_val;
    end
  end

  // guest status fields; hypervisor copies stay untouched
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      guest_prior_privilege <= 1'b0;
      guest_prior_int_enable <= hte_pkg::RST_IE;
      guest_int_enable <= hte_pkg::RST_IE;
    end
    else if (to_vs)
    begin
      guest_prior_privilege <= privilege[0];
      guest_prior_int_enable <= guest_int_enable;
      guest_int_enable <= 1'b0;
    end
    else if (ie_wr_en)
      guest_int_enable <= ie_wr_val[2];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      guest_sup_exception_pc <= '0;
      guest_sup_trap_cause <= '0;
      guest_sup_trap_value <= '0;
    end
    else if (to_vs)
    begin
      guest_sup_exception_pc <= trap_pc;
      guest_sup_trap_cause <= cause;
      guest_sup_trap_value <= trap_tval;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_WFI_TIMEOUT: assert property (wfi_timeout |=> trap_taken && trap_cause == 64'h0000_0000_0000_0002)
    else $error("wfi timeout did not raise illegal instruction");
  AST_WFI_BOUND: assert property (wfi_waiting && wfi_timed |-> wfi_cnt_reg <= hte_pkg::WFI_LAST)
    else $error("wfi wait ran past its limit");
  AST_VSSI_CODE: assert property (int_pending == 16'h0004 |=> trap_taken && trap_cause[63] && trap_cause[5:0] == 6'h02)
    else $error("virtual software interrupt cause wrong");
  AST_VSTI_CODE: assert property (int_pending == 16'h0040 |=> trap_taken && trap_cause[63] && trap_cause[5:0] == 6'h06)
    else $error("virtual timer interrupt cause wrong");
  AST_VSEI_CODE: assert property (int_pending == 16'h0400 |=> trap_taken && trap_cause[63] && trap_cause[5:0] == 6'h0a)
    else $error("virtual external interrupt cause wrong");
  AST_SGEI_CODE: assert property (int_pending == 16'h1000 |=> trap_taken && trap_cause[63] && trap_cause[5:0] == 6'h0c)
    else $error("guest external interrupt cause wrong");
  AST_RSVD_IRQ: assert property (int_pending == 16'he111 && !exc_valid && !environment_call_instr_valid && !wfi_timeout |=> !trap_taken)
    else $error("reserved interrupt code taken");
  AST_ENVIRONMENT_CALL_INSTR_VS: assert property (int_pending == 16'h0000 && environment_call_instr_valid && guest_context_flag
    && privilege == hte_pkg::PRIV_S |=> trap_cause == 64'h0000_0000_0000_000a)
    else $error("guest supervisor environment call cause wrong");
  AST_M_ENTRY: assert property (trap_taken && trap_target == hte_pkg::HTE_TO_M |-> !guest_context_flag
    && machine_prior_guest_flag == $past(guest_context_flag) && machine_prior_privilege == $past(privilege))
    else $error("machine entry prior mode wrong");
  AST_SUP_PRIOR_GUEST_PRIVILEGE_KEEP: assert property (trap_taken && trap_target == hte_pkg::HTE_TO_HS && !$past(guest_context_flag)
    |-> $stable(sup_prior_guest_privilege))
    else $error("prior guest privilege changed from host");
  AST_VS_KEEP: assert property (trap_taken && trap_target == hte_pkg::HTE_TO_VS |-> guest_context_flag
    && $stable(sup_prior_guest_flag) && $stable(sup_prior_privilege) && $stable(sup_int_enable))
    else $error("guest entry disturbed hypervisor status");
  AST_INT_TINST: assert property (trap_taken && trap_cause[63] && trap_target == hte_pkg::HTE_TO_M
    |-> machine_trap_instr == 64'h0000_0000_0000_0000)
    else $error("interrupt wrote nonzero trap instruction");
  AST_GPF_DELEG: assert property (trap_taken && trap_target == hte_pkg::HTE_TO_VS |-> trap_cause[63]
    || !(trap_cause[5:0] inside {6'h14, 6'h15, 6'h17}))
    else $error("guest-page fault delegated to guest");

  COV_TO_VS: cover property (trap_taken && trap_target == hte_pkg::HTE_TO_VS);
  COV_GPF_HS: cover property (trap_taken && trap_target == hte_pkg::HTE_TO_HS && trap_cause[5:0] == 6'h15);
  COV_WFI_TO: cover property (wfi_timeout);
endmodule
`default_nettype wire

// ### sim/hte_pipe_model.sv
// behavioural pipeline that raises traps, returns and wait requests
`timescale 1ns/1ps
`default_nettype none
module hte_pipe_model (
  input wire logic core_clk,
  output var logic [15:0] int_pending,
  output var logic exc_valid,
  output var logic [5:0] exc_code,
  output var logic environment_call_instr_valid,
  output var logic wfi_valid,
  output var logic wfi_wake,
  output var logic mret_valid,
  output var logic [63:0] trap_pc,
  output var logic [63:0] trap_tval,
  output var logic [63:0] trap_gpa,
  output var logic [63:0] trap_tinst,
  output var logic trap_gva,
  output var logic [63:0] mach_exc_deleg,
  output var logic [63:0] mach_int_deleg,
  output var logic [63:0] hyp_exc_deleg,
  output var logic [63:0] hyp_int_deleg,
  output var logic ie_wr_en,
  output var logic [2:0] ie_wr_val
);
  initial
  begin
    {int_pending, exc_valid, exc_code, environment_call_instr_valid, wfi_valid, wfi_wake, mret_valid} = '0;
    {trap_pc, trap_tval, trap_gpa, trap_tinst, trap_gva, ie_wr_en, ie_wr_val} = '0;
    {mach_exc_deleg, mach_int_deleg, hyp_exc_deleg, hyp_int_deleg} = '0;
  end

  // kind 0 fault, 1 env call, 2 wait, 3 return, 4 irq, 5 enable write, 6 delegation, 7 wake
  task automatic pulse(input int kind, input logic [5:0] code, input logic [63:0] arg);
    @(posedge core_clk);
    exc_code <= code;
    trap_pc <= arg + 64'h0000_0000_0000_0004;
    trap_tval <= arg;
    trap_gpa <= arg;
    trap_tinst <= ~arg;
    ie_wr_val <= code[2:0];
    case (kind)
      0: exc_valid <= 1'b1;
      1: environment_call_instr_valid <= 1'b1;
      2: wfi_valid <= 1'b1;
      3: mret_valid <= 1'b1;
      4: int_pending <= 16'h0001 << code;
      5: ie_wr_en <= 1'b1;
      6: mach_exc_deleg <= arg;
      default: wfi_wake <= 1'b1;
    endcase
    @(posedge core_clk);
    {exc_valid, environment_call_instr_valid, wfi_valid, mret_valid, wfi_wake, ie_wr_en} <= '0;
    int_pending <= '0;
    // stale data is inverted so nothing relies on it lingering
    trap_tval <= ~arg;
    trap_gpa <= ~arg;
    trap_tinst <= arg;
  endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the trap-entry block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n;
  wire logic [15:0] int_pending;
  wire logic [5:0] exc_code;
  wire logic [2:0] ie_wr_val;
  wire logic exc_valid, environment_call_instr_valid, wfi_valid, wfi_wake, mret_valid, trap_gva, ie_wr_en;
  wire logic [63:0] trap_pc, trap_tval, trap_gpa, trap_tinst;
  wire logic [63:0] mach_exc_deleg, mach_int_deleg, hyp_exc_deleg, hyp_int_deleg;
  logic [1:0] privilege, machine_prior_privilege;
  logic guest_context_flag, wfi_waiting, trap_taken, machine_prior_guest_flag;
  logic machine_prior_int_enable, machine_int_enable, sup_prior_guest_flag, sup_prior_privilege;
  logic [63:0] machine_exception_pc, machine_trap_cause, machine_trap_value_two, machine_trap_instr;
  logic [63:0] sup_trap_cause, hyp_trap_value, trap_cause, sup_exception_pc;
  logic sup_prior_guest_privilege, sup_int_enable;
  hte_pkg::hte_target_t trap_target;
  logic [5:0] icode [4] = '{6'h02, 6'h06, 6'h0a, 6'h0c};
  logic [5:0] ecode [6] = '{6'h14, 6'h15, 6'h17, 6'h0e, 6'h16, 6'h28};

  always #25 core_clk = ~core_clk;

  hte_pipe_model pipe (.core_clk, .int_pending, .exc_valid, .exc_code, .environment_call_instr_valid, .wfi_valid, .wfi_wake,
    .mret_valid, .trap_pc, .trap_tval, .trap_gpa, .trap_tinst, .trap_gva, .mach_exc_deleg, .mach_int_deleg,
    .hyp_exc_deleg, .hyp_int_deleg, .ie_wr_en, .ie_wr_val);

  hte_trap_entry dut (.core_clk, .rst, .int_pending, .exc_valid, .exc_code, .environment_call_instr_valid, .wfi_valid,
    .wfi_wake, .mret_valid, .trap_pc, .trap_tval, .trap_gpa, .trap_tinst, .trap_gva, .mach_exc_deleg,
    .mach_int_deleg, .hyp_exc_deleg, .hyp_int_deleg, .ie_wr_en, .ie_wr_val, .privilege, .guest_context_flag,
    .wfi_waiting, .trap_taken, .trap_target, .trap_cause, .machine_prior_guest_flag, .machine_prior_privilege,
    .guest_address_flag(), .machine_prior_int_enable, .machine_int_enable, .machine_exception_pc,
    .machine_trap_cause, .machine_trap_value(), .machine_trap_value_two, .machine_trap_instr,
    .sup_prior_guest_flag, .sup_prior_privilege, .sup_prior_guest_privilege, .hyp_guest_address_flag(),
    .sup_prior_int_enable(), .sup_int_enable, .sup_exception_pc, .sup_trap_cause, .sup_trap_value(),
    .hyp_trap_value, .hyp_trap_instr(), .guest_prior_privilege(), .guest_prior_int_enable(),
    .guest_int_enable(), .guest_sup_exception_pc(), .guest_sup_trap_cause(), .guest_sup_trap_value());

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic op(input int kind, input logic [5:0] code, input logic [63:0] arg);
    pipe.pulse(kind, code, arg);
    #1;
  endtask

  task automatic mtrap(input logic [63:0] cause, input logic [1:0] prior);
    check("trap_taken", trap_taken, 64'h1);
    check("privilege", privilege, 64'h3);
    check("guest_context_flag", guest_context_flag, 64'h0);
    check("machine_trap_cause", machine_trap_cause, cause);
    check("trap_cause", trap_cause, cause);
    check("trap_target", trap_target, 64'(hte_pkg::HTE_TO_M));
    check("machine_prior_privilege", machine_prior_privilege, 64'(prior));
    check("machine_prior_guest_flag", machine_prior_guest_flag, 64'h0);
  endtask

  // a hang cuts the run short through the same closing report
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      $display("unexpected timeout: expected finish seen %0d cycles", cycles);
      finish_test();
    end
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    check("privilege", privilege, 64'h3);
    check("trap_target", trap_target, 64'(hte_pkg::HTE_TO_M));
    op(3, 6'h00, 64'h0);
    check("privilege", privilege, 64'h0);
    op(2, 6'h00, 64'h0);
    for (n = 0; n < 260 && trap_taken !== 1'b1; n++)
    begin
      @(posedge core_clk);
      #1;
    end
    check("wfi_cycles", 64'(n), 64'd200);
    mtrap(64'h2, 2'h0);
    op(2, 6'h00, 64'h0);
    repeat (210) @(posedge core_clk);
    #1;
    check("wfi_waiting", wfi_waiting, 64'h1);
    check("trap_taken", trap_taken, 64'h0);
    op(7, 6'h00, 64'h0);
    check("wfi_waiting", wfi_waiting, 64'h0);
    $display("test wait done");
    op(3, 6'h00, 64'h0);
    op(5, 6'h01, 64'h0);
    check("machine_int_enable", machine_int_enable, 64'h1);
    op(1, 6'h00, 64'h1000);
    mtrap(64'h8, 2'h0);
    check("machine_prior_int_enable", machine_prior_int_enable, 64'h1);
    check("machine_int_enable", machine_int_enable, 64'h0);
    check("machine_exception_pc", machine_exception_pc, 64'h1004);
    check("machine_trap_instr", machine_trap_instr, ~64'h1000);
    op(1, 6'h00, 64'h0);
    mtrap(64'hb, 2'h3);
    op(3, 6'h00, 64'h0);
    check("privilege", privilege, 64'h3);
    check("guest_context_flag", guest_context_flag, 64'h0);
    op(3, 6'h00, 64'h0);
    check("privilege", privilege, 64'h0);
    $display("test env call done");
    for (int i = 0; i < 4; i++)
    begin
      op(4, icode[i], 64'h0);
      mtrap(64'h8000_0000_0000_0000 | 64'(icode[i]), (i == 0) ? 2'h0 : 2'h3);
      check("machine_trap_instr", machine_trap_instr, 64'h0);
    end
    op(4, 6'h0d, 64'h0);
    check("trap_taken", trap_taken, 64'h0);
    for (int i = 0; i < 6; i++)
    begin
      op(0, ecode[i], 64'h0000_0000_0001_2340);
      if (i < 3)
      begin
        mtrap(64'(ecode[i]), 2'h3);
        check("machine_trap_value_two", machine_trap_value_two, 64'h0000_0000_0000_48d0);
      end
      else
        check("trap_taken", trap_taken, 64'h0);
    end
    $display("test cause codes done");
    op(3, 6'h00, 64'h0);
    op(3, 6'h00, 64'h0);
    op(6, 6'h00, 64'h0000_0000_0020_0100);
    op(1, 6'h00, 64'h0);
    check("privilege", privilege, 64'h1);
    check("trap_target", trap_target, 64'(hte_pkg::HTE_TO_HS));
    check("sup_trap_cause", sup_trap_cause, 64'h8);
    check("sup_prior_privilege", sup_prior_privilege, 64'h0);
    check("sup_prior_guest_flag", sup_prior_guest_flag, 64'h0);
    check("sup_exception_pc", sup_exception_pc, 64'h4);
    check("sup_int_enable", sup_int_enable, 64'h0);
    check("sup_prior_guest_privilege", sup_prior_guest_privilege, 64'h0);
    op(0, 6'h15, 64'h0000_0000_0000_8888);
    check("sup_trap_cause", sup_trap_cause, 64'h15);
    check("hyp_trap_value", hyp_trap_value, 64'h0000_0000_0000_2222);
    check("sup_prior_privilege", sup_prior_privilege, 64'h1);
    op(1, 6'h00, 64'h0);
    mtrap(64'h9, 2'h1);
    $display("test delegation done");
    finish_test();
  end
endmodule
`default_nettype wire
